// ### pkg/phase_scaler_params.svh
// phase_scaler_params.svh: offsets, field positions, reset values and limits for the phase scaler.
// assumes inclusion by bare name from the design files; definitions only.
`ifndef PHASE_SCALER_PARAMS_SVH
`define PHASE_SCALER_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_EXPONENTS 12'h000
`define OFS_NUMERATOR 12'h004
`define OFS_DENOMINATOR 12'h008
`define OFS_CONTROL 12'h00c
`define OFS_STATUS 12'h010
`define OFS_SCALER_OUT 12'h014
`define OFS_CHAN12_OUT 12'h018
`define OFS_CHAN3_OUT 12'h01c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FLD_EXP_CH1 0
`define FLD_EXP_CH2 8
`define FLD_EXP_CH3 16
`define FLD_CTRL_ACT_SEL 0
`define FLD_CTRL_ACT_SW 1
`define FLD_CTRL_CLR_REM 2
`define FLD_STAT_EMPTY 0
`define FLD_STAT_FULL 1
`define FLD_STAT_DEN_ZERO 2
`define FLD_STAT_ACT 3

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define RST_EXPONENT 5'h00
`define RST_NUMERATOR 16'h0001
`define RST_DENOMINATOR 16'h0001
`define ANALOG_FULL_SCALE 16384
`define ANALOG_MAX 33'sh0_0000_7fff
`define ANALOG_MIN (-33'sh0_0000_7fff)
`define FIFO_DEPTH 16

`endif

// ### pkg/phase_scaler_pkg.sv
// phase_scaler_pkg: shared types of the phase scaler.
// assumes nothing beyond a SystemVerilog compiler.
package phase_scaler_pkg;
  typedef logic signed [31:0] phase_t;   // signed increment count
  typedef logic signed [15:0] analog_t;  // 16384 counts = 100 %
  typedef logic signed [15:0] factor_t;  // numerator / denominator
  typedef logic [4:0] exp_t;             // power-of-two exponent
endpackage : phase_scaler_pkg

// ### rtl/word_fifo.sv
// word_fifo: synchronous FIFO with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic not_full;
  } fifo_s;

  fifo_s st_q;
  fifo_s st_d;
  logic push;
  logic pop;

  assign push = in_valid && st_q.not_full;
  assign pop = out_valid && out_ready;
  assign in_ready = st_q.not_full;
  assign out_valid = (st_q.count != '0);
  assign out_data = st_q.mem[st_q.rd];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // ready is registered from the next count so the source sees a clean level
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = st_q.wr + PW'(1);
    end
    if (pop) begin
      st_d.rd = st_q.rd + PW'(1);
    end
    st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
    st_d.not_full = (st_d.count != (PW+1)'(DEPTH));
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.not_full <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : word_fifo

// ### rtl/phase_signal_scaler.sv
// phase_signal_scaler: three phase-to-analog channels and a phase-to-phase scaler, APB registers.
// assumes all inputs come from logic on mclk; APB master on the same clock.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "phase_scaler_params.svh"
module phase_signal_scaler (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // phase-to-analog channels
  input wire logic pha_sample_valid,
  input wire phase_scaler_pkg::phase_t pha_chan1_phase_in,
  input wire phase_scaler_pkg::phase_t pha_chan2_phase_in,
  input wire phase_scaler_pkg::phase_t pha_chan3_phase_in,
  output phase_scaler_pkg::analog_t pha_chan1_analog_out,
  output phase_scaler_pkg::analog_t pha_chan2_analog_out,
  output phase_scaler_pkg::analog_t pha_chan3_analog_out,
  output logic pha_out_valid,
  // phase scaler stream
  input wire logic scaler_activate,
  input wire logic scaler_in_valid,
  input wire phase_scaler_pkg::phase_t scaler_phase_in,
  output logic scaler_in_ready,
  output logic scaler_out_valid,
  output phase_scaler_pkg::phase_t scaler_phase_out,
  input wire logic scaler_out_ready,
  // parameter displays
  output phase_scaler_pkg::factor_t numerator_display,
  output phase_scaler_pkg::factor_t denominator_display
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0][4:0] exps;
    logic [15:0] num;
    logic [15:0] den;
    logic act_sel;          // 1: software bit drives activate
    logic act_sw;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [2:0][15:0] ana;
    logic ana_valid;
    logic [31:0] ch3_res;   // residual lost in the channel three shift
    logic signed [63:0] rem;
    logic [31:0] sout;
    logic sout_valid;
  } top_s;

  top_s st_q;
  top_s st_d;

  // ------------------------------------------------------------
  // fifo in front of the scaler
  // ------------------------------------------------------------
  logic f_in_ready;
  logic f_out_valid;
  logic [31:0] f_out_data;
  logic f_pop;

  word_fifo #(
    .WIDTH(32),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(scaler_in_valid),
    .in_data(scaler_phase_in),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_pop)
  );

  // ------------------------------------------------------------
  // phase-to-analog channels
  // ------------------------------------------------------------
  phase_scaler_pkg::phase_t ch_in [3];
  logic [2:0][15:0] ch_ana;
  logic [2:0][31:0] ch_res;

  assign ch_in[0] = pha_chan1_phase_in;
  assign ch_in[1] = pha_chan2_phase_in;
  assign ch_in[2] = pha_chan3_phase_in;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      logic signed [32:0] sum;
      logic signed [32:0] shifted;
      logic [32:0] mask;
      // only channel three adds back its residual; the others drop it
      if (gi == 2) begin : g_res
        assign sum = {ch_in[gi][31], ch_in[gi]} + $signed({1'b0, st_q.ch3_res});
      end else begin : g_nores
        assign sum = {ch_in[gi][31], ch_in[gi]};
      end
      assign shifted = sum >>> st_q.exps[gi];
      assign mask = ~({33{1'b1}} << st_q.exps[gi]);
      assign ch_res[gi] = 32'(sum & $signed(mask));
      // one shifted count is 100/16384 %, so the code itself is the scaled value
      assign ch_ana[gi] = (shifted > `ANALOG_MAX) ? 16'h7fff :
                          (shifted < `ANALOG_MIN) ? 16'h8001 :
                          shifted[15:0];
    end
  endgenerate

  // ------------------------------------------------------------
  // phase-to-phase scaler arithmetic
  // ------------------------------------------------------------
  logic eff_act;
  logic signed [31:0] operand;
  logic [15:0] den_abs;
  logic signed [63:0] prod;
  logic signed [63:0] total;
  logic signed [63:0] quot;
  logic den_zero;

  assign eff_act = st_q.act_sel ? st_q.act_sw : scaler_activate;
  assign operand = eff_act ? $signed(f_out_data) : 32'sh0000_0000;
  // absolute value of -32768 fits in 16 unsigned bits
  assign den_abs = st_q.den[15] ? 16'(-st_q.den) : st_q.den;
  assign den_zero = (st_q.den == 16'h0000);
  // 48-bit product held in 64 bits so nothing wraps before the division
  assign prod = 64'(operand) * 64'($signed(st_q.num));
  assign total = prod + st_q.rem;
  assign quot = den_zero ? 64'sh0 : total / $signed({48'h0, den_abs});

  // a zero denominator stalls the stream rather than producing garbage
  assign f_pop = f_out_valid && !den_zero && (!st_q.sout_valid || scaler_out_ready);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_val;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && st_q.ready && pwrite && !st_q.slverr;

  // read mux, also decides which addresses are mapped
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `OFS_EXPONENTS: begin
        rd_val[`FLD_EXP_CH1 +: 5] = st_q.exps[0];
        rd_val[`FLD_EXP_CH2 +: 5] = st_q.exps[1];
        rd_val[`FLD_EXP_CH3 +: 5] = st_q.exps[2];
      end
      `OFS_NUMERATOR: begin
        rd_val[15:0] = st_q.num;
      end
      `OFS_DENOMINATOR: begin
        rd_val[15:0] = st_q.den;
      end
      `OFS_CONTROL: begin
        rd_val[`FLD_CTRL_ACT_SEL] = st_q.act_sel;
        rd_val[`FLD_CTRL_ACT_SW] = st_q.act_sw;
      end
      `OFS_STATUS: begin
        rd_val[`FLD_STAT_EMPTY] = !f_out_valid;
        rd_val[`FLD_STAT_FULL] = !f_in_ready;
        rd_val[`FLD_STAT_DEN_ZERO] = den_zero;
        rd_val[`FLD_STAT_ACT] = eff_act;
      end
      `OFS_SCALER_OUT: begin
        rd_val = st_q.sout;
      end
      `OFS_CHAN12_OUT: begin
        rd_val = {st_q.ana[1], st_q.ana[0]};
      end
      `OFS_CHAN3_OUT: begin
        rd_val[15:0] = st_q.ana[2];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // answer is prepared in setup and presented for exactly one access cycle
    st_d.ready = setup;
    if (setup) begin
      st_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
      st_d.slverr = !rd_hit;
    end
    if (wr_en) begin
      case (paddr)
        `OFS_EXPONENTS: begin
          st_d.exps[0] = pwdata[`FLD_EXP_CH1 +: 5];
          st_d.exps[1] = pwdata[`FLD_EXP_CH2 +: 5];
          st_d.exps[2] = pwdata[`FLD_EXP_CH3 +: 5];
        end
        `OFS_NUMERATOR: begin
          st_d.num = pwdata[15:0];
        end
        `OFS_DENOMINATOR: begin
          st_d.den = pwdata[15:0];
        end
        `OFS_CONTROL: begin
          st_d.act_sel = pwdata[`FLD_CTRL_ACT_SEL];
          st_d.act_sw = pwdata[`FLD_CTRL_ACT_SW];
        end
        default: begin
        end
      endcase
    end
    // channels update together on each sample strobe
    st_d.ana_valid = pha_sample_valid;
    if (pha_sample_valid) begin
      st_d.ana = ch_ana;
      st_d.ch3_res = ch_res[2];
    end
    // output register of the scaler stream
    if (st_q.sout_valid && scaler_out_ready) begin
      st_d.sout_valid = 1'b0;
    end
    if (f_pop) begin
      st_d.sout = quot[31:0];
      st_d.sout_valid = 1'b1;
      st_d.rem = total - quot * $signed({48'h0, den_abs});
    end
    // clearing the remainder loses to a result landing in the same cycle
    if (wr_en && paddr == `OFS_CONTROL && pwdata[`FLD_CTRL_CLR_REM] && !f_pop) begin
      st_d.rem = 64'sh0;
    end
    if (wr_en && paddr == `OFS_CONTROL && pwdata[`FLD_CTRL_CLR_REM] && !pha_sample_valid) begin
      st_d.ch3_res = 32'h0000_0000;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.exps <= {3{`RST_EXPONENT}};
      st_q.num <= `RST_NUMERATOR;
      st_q.den <= `RST_DENOMINATOR;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from the state register except scaler_in_ready, which comes from the fifo
  // ------------------------------------------------------------
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.ready && st_q.slverr;
  assign pha_chan1_analog_out = st_q.ana[0];
  assign pha_chan2_analog_out = st_q.ana[1];
  assign pha_chan3_analog_out = st_q.ana[2];
  assign pha_out_valid = st_q.ana_valid;
  assign scaler_in_ready = f_in_ready; // fifo flip-flop: a copy one cycle late would lose or repeat words
  assign scaler_out_valid = st_q.sout_valid;
  assign scaler_phase_out = st_q.sout;
  assign numerator_display = st_q.num;
  assign denominator_display = st_q.den;
endmodule : phase_signal_scaler

// ### testbench/phase_signal_scaler_props.sv
// checker for phase_signal_scaler: timing and value relations at its ports.
// assumes one clock mclk with a synchronous active-high rst.
`timescale 1ns/1ps
module phase_signal_scaler_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // channels
  input wire logic pha_sample_valid,
  input wire phase_scaler_pkg::phase_t pha_chan1_phase_in,
  input wire phase_scaler_pkg::phase_t pha_chan2_phase_in,
  input wire phase_scaler_pkg::analog_t pha_chan1_analog_out,
  input wire phase_scaler_pkg::analog_t pha_chan2_analog_out,
  input wire phase_scaler_pkg::analog_t pha_chan3_analog_out,
  input wire logic pha_out_valid,
  // scaler output
  input wire logic scaler_out_valid,
  input wire phase_scaler_pkg::phase_t scaler_phase_out,
  input wire logic scaler_out_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // channel timing and values
  // ------------------------------------------------------------
  property p_pha_valid; pha_sample_valid |=> pha_out_valid; endproperty
  a_pha_valid: assert property (p_pha_valid) else $error("no result after sample");
  property p_pha_pulse; pha_out_valid |-> $past(pha_sample_valid); endproperty
  a_pha_pulse: assert property (p_pha_pulse) else $error("result without sample");
  // channel one and two outputs must hold between samples, a consumer may read them late
  property p_pha_hold;
    !pha_sample_valid |=> $stable(pha_chan1_analog_out) && $stable(pha_chan2_analog_out);
  endproperty
  a_pha_hold: assert property (p_pha_hold) else $error("analog output moved");
  property p_zero; pha_sample_valid && pha_chan1_phase_in == 0 |=> pha_chan1_analog_out == 0; endproperty
  a_zero: assert property (p_zero) else $error("zero input gave nonzero");
  property p_sign; pha_sample_valid && pha_chan1_phase_in < 0 |=> pha_chan1_analog_out < 0; endproperty
  a_sign: assert property (p_sign) else $error("floor shift lost sign");
  property p_shrink;
    pha_sample_valid && pha_chan2_phase_in >= 0 && pha_chan2_phase_in <= 32767
    |=> pha_chan2_analog_out >= 0 && pha_chan2_analog_out <= $past(pha_chan2_phase_in);
  endproperty
  a_shrink: assert property (p_shrink) else $error("shift grew value");
  property p_limit; pha_out_valid |-> pha_chan3_analog_out != -16'sd32768; endproperty
  a_limit: assert property (p_limit) else $error("analog out of limit");
  // ------------------------------------------------------------
  // scaler stream
  // ------------------------------------------------------------
  property p_out_hold;
    scaler_out_valid && !scaler_out_ready |=> scaler_out_valid && $stable(scaler_phase_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("result dropped in stall");
endmodule : phase_signal_scaler_props
bind phase_signal_scaler phase_signal_scaler_props i_props (.mclk, .rst, .pha_sample_valid,
  .pha_chan1_phase_in, .pha_chan2_phase_in, .pha_chan1_analog_out, .pha_chan2_analog_out,
  .pha_chan3_analog_out, .pha_out_valid, .scaler_out_valid, .scaler_phase_out, .scaler_out_ready);

// ### testbench/phase_sink.sv
// phase_sink: far-side consumer of the scaler stream, prompt, paced or stalled.
// assumes the stream on mclk; every accepted word lands in got.
`timescale 1ns/1ps
module phase_sink (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pacing
  input wire logic stall,
  input wire logic slow,
  // stream
  input wire logic out_valid,
  input wire phase_scaler_pkg::phase_t out_data,
  output logic out_ready
);
  logic tgl_q;
  phase_scaler_pkg::phase_t got[$];
  // paced mode takes every other cycle so the producer must hold its word
  assign out_ready = !stall && !(slow && tgl_q);
  // ------------------------------------------------------------
  // collect at the completing edge
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    tgl_q <= rst ? 1'b0 : !tgl_q;
    if (!rst && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule : phase_sink

// ### testbench/phase_signal_scaler_test.sv
// phase_signal_scaler_test: directed tests over APB, the channels and the scaler stream.
// assumes phase_sink as consumer and the checker bound to the design.
`timescale 1ns/1ps
`include "phase_scaler_params.svh"
module phase_signal_scaler_test;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pv, pov, act, iv, ir, ov, ordy, stall, slow;
  phase_scaler_pkg::phase_t in1, in2, in3, sin, sout;
  phase_scaler_pkg::analog_t o1, o2, o3;
  phase_scaler_pkg::factor_t nd, dd;
  int n_mismatch = 0, total_checks = 0, cyc = 0, acc;
  longint rem = 0, res3 = 0, num = 3, den = 2, exq[$];
  logic sel = 1'b0, sw = 1'b0; // model of the control activate select and software bit
  phase_signal_scaler i_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pha_sample_valid(pv), .pha_chan1_phase_in(in1), .pha_chan2_phase_in(in2),
    .pha_chan3_phase_in(in3), .pha_chan1_analog_out(o1), .pha_chan2_analog_out(o2),
    .pha_chan3_analog_out(o3), .pha_out_valid(pov), .scaler_activate(act), .scaler_in_valid(iv),
    .scaler_phase_in(sin), .scaler_in_ready(ir), .scaler_out_valid(ov), .scaler_phase_out(sout),
    .scaler_out_ready(ordy), .numerator_display(nd), .denominator_display(dd));
  phase_sink i_sink (.mclk, .rst, .stall, .slow, .out_valid(ov), .out_data(sout), .out_ready(ordy));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  function automatic longint cv(input longint x, input int e);
    longint q;
    q = x >>> e;
    return q > 32767 ? 32767 : (q < -32767 ? -32767 : q);
  endfunction : cv
  // truncating division with the remainder carried into the next word
  function automatic longint scl(input longint x);
    longint t, q;
    t = ((sel ? sw : act) ? x : 0) * num + rem;
    q = t / den;
    rem = t - q * den;
    return q;
  endfunction : scl
  task automatic pha(input longint a, input longint b, input longint c);
    longint s;
    pv <= 1'b1;
    in1 <= a[31:0];
    in2 <= b[31:0];
    in3 <= c[31:0];
    @(posedge mclk);
    pv <= 1'b0;
    @(posedge mclk);
    s = c + res3;
    chk(pov, 1'b1);
    chk(o1, cv(a, 2));
    chk(o2, cv(b, 0));
    chk(o3, cv(s, 4));
    res3 = s - ((s >>> 4) <<< 4);
  endtask : pha
  task automatic push(input longint x);
    iv <= 1'b1;
    sin <= x[31:0];
    exq.push_back(scl(x));
    @(posedge mclk);
    while (ir !== 1'b1) @(posedge mclk);
    iv <= 1'b0;
    @(posedge mclk);
  endtask : push
  task automatic drain();
    for (int k = 0; k < 400 && i_sink.got.size() < exq.size(); k++) @(posedge mclk);
    chk(i_sink.got.size(), exq.size());
    foreach (exq[i]) chk(i_sink.got[i], exq[i]);
    i_sink.got.delete();
    exq.delete();
  endtask : drain
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // clock, timeout and tests
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run needs well under 2000 cycles; a hang ends here
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pv, in1, in2, in3, act, iv, sin, stall, slow} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    apb(`OFS_NUMERATOR, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(12'h020, 1'b0, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    apb(`OFS_EXPONENTS, 1'b1, 32'h0004_0002);
    apb(`OFS_NUMERATOR, 1'b1, 32'h3);
    apb(`OFS_DENOMINATOR, 1'b1, 32'hfffe);
    apb(`OFS_CONTROL, 1'b1, 32'h1);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(`OFS_CONTROL, 1'b1, 32'h0);
    chk(dd, -16'sd2);
    chk(nd, 16'sd3);
    pha(65536, 70000, 20);
    pha(-65536, -100000, 20);
    pha(-1, 32767, 20);
    pha(0, 0, 20);
    apb(`OFS_CHAN3_OUT, 1'b0, 32'h0);
    chk(rd, 32'h2);
    $display("test channels done");
    act <= 1'b1;
    slow <= 1'b1;
    @(posedge mclk);
    push(5); // operands stay far inside 32 bits
    push(5);
    push(-5);
    push(-5);
    drain();
    act <= 1'b0;
    @(posedge mclk);
    push(99);
    push(7);
    drain();
    $display("test scaler done");
    act <= 1'b1;
    stall <= 1'b1;
    slow <= 1'b0;
    iv <= 1'b1;
    sin <= 1;
    acc = 0;
    repeat (30) begin
      @(posedge mclk);
      if (ir === 1'b1) begin
        acc++;
        exq.push_back(scl(sin));
        sin <= sin + 1;
      end
    end
    iv <= 1'b0;
    @(posedge mclk);
    chk(acc, 17); // sixteen fifo words and one in the output register
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'ha);
    stall <= 1'b0;
    slow <= 1'b1;
    drain();
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h9);
    apb(`OFS_SCALER_OUT, 1'b0, 32'h0);
    chk(rd, 32'h19);
    $display("test fifo done");
    act <= 1'b0;
    apb(`OFS_CONTROL, 1'b1, 32'h7);
    sel = 1'b1;
    sw = 1'b1;
    rem = 0; // the clear bit drops the carried remainder
    apb(`OFS_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h3);
    push(1); // software bit activates although the pin is low
    drain();
    $display("test control done");
    finish_test();
  end
endmodule : phase_signal_scaler_test
